// ---- mesam_pkg.sv ----
// mesam_pkg: register map, field positions and reset values of the
// metering event, status and mask block.
// assumes a 12-bit word address on a plain strobe port with 32-bit data.
package mesam_pkg;

  // register word addresses, kept at the printed offsets
  localparam logic [11:0] OFS_NOLOAD_CHANGE = 12'h402;
  localparam logic [11:0] OFS_EVENT_LEVEL = 12'h404;
  localparam logic [11:0] OFS_INT_ENABLE_LOW = 12'h405;
  localparam logic [11:0] OFS_NOLOAD_MASK = 12'h407;
  localparam logic [11:0] OFS_SOFT_RESET = 12'h408;
  localparam logic [11:0] OFS_PHASE_NOLOAD = 12'h409;

  // sticky status layout (noload_change_flags)
  localparam int CHG_LSB = 0;
  localparam int CHG_W = 5;
  localparam int EVT_LSB = 18;
  localparam int EVT_W = 8;
  localparam int ERR_LSB = 28;
  localparam int ERR_W = 2;

  // event_level_flags layout
  localparam int LVL_DIP_LSB = 0;
  localparam int LVL_SWELL_LSB = 3;
  localparam int LVL_SIGN_LSB = 6;
  localparam int LVL_NOLOAD_LSB = 10;
  localparam int LVL_WFREADY_BIT = 16;

  // interrupt_enable_low: bits 31..26 reserved, read as zero
  localparam int MASK_W = 26;

  // soft reset control bit
  localparam int SOFT_RESET_BIT = 0;

  // no-load input: six energy types, three phases each
  localparam int NL_TYPES = 6;
  localparam int NL_PHASES = 3;
  localparam int NL_W = 18;

  // reset values
  localparam logic [31:0] STATUS_RST = 32'h0000_0000;
  localparam logic [MASK_W-1:0] MASK_RST = 26'h000_0000;
  localparam logic [CHG_W-1:0] NL_MASK_RST = 5'h00;
  localparam logic [NL_W-1:0] PHASE_NL_RST = 18'h0_0000;
  localparam logic [31:0] READ_IDLE = 32'h0000_0000;

endpackage : mesam_pkg

// ---- mesam_pulse_sync.sv ----
// mesam_pulse_sync: two-stage synchroniser for pulse pins and a
// high-to-low edge detector on the synchronised level.
// assumes pin pulses last at least two core_clk periods.
`timescale 1ns/1ps
module mesam_pulse_sync #(
  parameter int W = 4
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [W-1:0] pinIn,
  output logic [W-1:0] fallPulse
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] prev_q;
  logic [W-1:0] fall_q;

  // first stage is read only by the second
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= pinIn;
      sync_q <= meta_q;
    end
  end

  // falling edge seen on the clean level, one-cycle pulse
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      prev_q <= '0;
      fall_q <= '0;
    end else begin
      prev_q <= sync_q;
      fall_q <= prev_q & ~sync_q;
    end
  end

  assign fallPulse = fall_q;

endmodule : mesam_pulse_sync

// ---- mesam_ctrl.sv ----
// mesam_ctrl: latched no-load change flags, event level register,
// interrupt mask and the single interrupt request of the metering core.
// assumes metrology inputs are on core_clk; pulse pins are asynchronous.
//
// Functional notes
// - latch total active/reactive/apparent no-load change bits 0..2, record phase
// - latch fundamental active/reactive no-load change bits 3..4, record phase
// - event bit 16 rises to one when new waveform samples are ready
// - total no-load level bits 10..12 high while all phases out of no load
// - fundamental no-load level bits 13..15 high while all phases out
// - sign bits 6..9 per pulse output: one positive, zero negative energy
// - sign bits update only on high-to-low edge of the pulse pin
// - swell level bits 3..5 follow phase A..C swell condition
// - dip level bits 0..2 follow phase A..C dip condition
// - temperature ready interrupt only with mask bit 25; bits 31..26 reserved
// - current-sum mismatch change interrupt only with mask bit 24
// - resampled buffer full interrupt only with mask bit 23
// - waveform trigger event interrupt only with mask bit 22
// - distortion and power factor update interrupt only with mask bit 21
// - multicycle rms update interrupt only with mask bit 20
// - half-cycle rms update interrupt only with mask bit 19
// - accumulated power update interrupt only with mask bit 18
// - two fatal errors are non-maskable, held until soft or hard reset
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
module mesam_ctrl
  import mesam_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  // register port
  input wire logic [11:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [31:0] regRdData,
  // per-phase no-load state, 3 bits per energy type
  input wire logic [17:0] noloadIn,
  input wire logic [2:0] dipIn,
  input wire logic [2:0] swellIn,
  // energy pulse pins and the sign of the energy behind each
  input wire logic energyPulseOut1,
  input wire logic energyPulseOut2,
  input wire logic energyPulseOut3,
  input wire logic energyPulseOut4,
  input wire logic [3:0] pulseSignIn,
  // one-cycle event strobes from metrology
  input wire logic waveformSampleReady,
  input wire logic tempReady,
  input wire logic currentSumMismatch,
  input wire logic resampledBufferFull,
  input wire logic waveformTrigger,
  input wire logic distortionPfReady,
  input wire logic multicycleRmsReady,
  input wire logic halfcycleRmsReady,
  input wire logic powerReady,
  input wire logic fatalError0,
  input wire logic fatalError1,
  // interrupt request, level, active high
  output logic irq
);

  // any phase of energy type t flagged in a packed no-load vector
  function automatic logic phaseOr(input logic [NL_W-1:0] v, input int t);
    logic r;
    r = 1'b0;
    for (int p = 0; p < NL_PHASES; p++) begin
      r = r | v[t*NL_PHASES+p];
    end
    return r;
  endfunction : phaseOr

  // address match qualified by a strobe
  function automatic logic hit(input logic en, input logic [11:0] a, input logic [11:0] o);
    return en && (a == o);
  endfunction : hit

  logic softRst_q;
  logic clrAll;
  logic [31:0] status_q;
  logic [31:0] statusSet;
  logic [31:0] statusClr;
  logic [MASK_W-1:0] interrupt_enable_low_q;
  logic [CHG_W-1:0] noloadMask_q;
  logic [NL_W-1:0] phaseNoload_q;
  logic armed_q;
  logic [NL_TYPES-1:0] noloadLevel_q;
  logic [CHG_W-1:0] noloadChange;
  logic [3:0] pulseSign_q;
  logic [3:0] pulseFall;
  logic [2:0] dip_q;
  logic [2:0] swell_q;
  logic wfReady_q;
  logic [EVT_W-1:0] evtVec;
  logic [31:0] eventLevel;
  logic [31:0] rdMux;
  logic [31:0] rdData_q;
  logic irq_q;
  logic [EVT_W-1:0] evtGate;
  logic chgHit;
  logic errHit;

  // software reset acts like the hard one on every held flag
  assign clrAll = !resetn || softRst_q;

  // soft reset strobe, one cycle after the write
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      softRst_q <= 1'b0;
    end else begin
      softRst_q <= hit(regWrEn, regAddr, OFS_SOFT_RESET) && regWrData[SOFT_RESET_BIT];
    end
  end

  // pulse pins arrive from outside core_clk, so they pass two flops
  mesam_pulse_sync #(
    .W(4)
  ) u_pulse_sync (
    .core_clk(core_clk),
    .resetn(resetn),
    .pinIn({energyPulseOut4, energyPulseOut3, energyPulseOut2, energyPulseOut1}),
    .fallPulse(pulseFall)
  );

  always_ff @(posedge core_clk) begin
    if (clrAll) begin
      pulseSign_q <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (pulseFall[i]) begin
          pulseSign_q[i] <= pulseSignIn[i];
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (clrAll) begin
      dip_q <= 3'h0;
    end else begin
      dip_q <= dipIn;
    end
  end

  always_ff @(posedge core_clk) begin
    if (clrAll) begin
      swell_q <= 3'h0;
    end else begin
      swell_q <= swellIn;
    end
  end

  always_ff @(posedge core_clk) begin
    if (clrAll) begin
      phaseNoload_q <= PHASE_NL_RST;
    end else begin
      phaseNoload_q <= noloadIn;
    end
  end

  // armed_q hides the first sample so reset
  // does not look like a change of every phase
  always_ff @(posedge core_clk) begin
    if (clrAll) begin
      armed_q <= 1'b0;
    end else begin
      armed_q <= 1'b1;
    end
  end

  always_comb begin
    noloadChange = '0;
    for (int t = 0; t < CHG_W; t++) begin
      noloadChange[t] = armed_q && phaseOr(noloadIn ^ phaseNoload_q, t);
    end
  end

  always_ff @(posedge core_clk) begin
    if (clrAll) begin
      noloadLevel_q <= '0;
    end else begin
      for (int t = 0; t < NL_TYPES; t++) begin
        noloadLevel_q[t] <= !phaseOr(noloadIn, t);
      end
    end
  end

  // sample-ready flag, cleared by reading the event register
  // a new sample in the read cycle keeps the flag up
  always_ff @(posedge core_clk) begin
    if (clrAll) begin
      wfReady_q <= 1'b0;
    end else if (waveformSampleReady) begin
      wfReady_q <= 1'b1;
    end else if (hit(regRdEn, regAddr, OFS_EVENT_LEVEL)) begin
      wfReady_q <= 1'b0;
    end
  end

  // event strobes in mask bit order, 25 down to 18
  assign evtVec = {tempReady, currentSumMismatch, resampledBufferFull, waveformTrigger,
                   distortionPfReady, multicycleRmsReady, halfcycleRmsReady, powerReady};

  // sticky set sources
  always_comb begin
    statusSet = '0;
    statusSet[CHG_LSB +: CHG_W] = noloadChange;
    statusSet[EVT_LSB +: EVT_W] = evtVec;
    statusSet[ERR_LSB +: ERR_W] = {fatalError1, fatalError0};
  end

  // write-one-to-clear; fatal errors are not clearable this way
  always_comb begin
    statusClr = '0;
    if (hit(regWrEn, regAddr, OFS_NOLOAD_CHANGE)) begin
      statusClr[CHG_LSB +: CHG_W] = regWrData[CHG_LSB +: CHG_W];
      statusClr[EVT_LSB +: EVT_W] = regWrData[EVT_LSB +: EVT_W];
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (clrAll) begin
      status_q <= STATUS_RST;
    end else begin
      status_q <= (status_q & ~statusClr) | statusSet;
    end
  end

  always_ff @(posedge core_clk) begin
    if (clrAll) begin
      interrupt_enable_low_q <= MASK_RST;
    end else if (hit(regWrEn, regAddr, OFS_INT_ENABLE_LOW)) begin
      interrupt_enable_low_q <= regWrData[MASK_W-1:0];
    end
  end

  // mask of the no-load change flags, same bit layout as status
  always_ff @(posedge core_clk) begin
    if (clrAll) begin
      noloadMask_q <= NL_MASK_RST;
    end else if (hit(regWrEn, regAddr, OFS_NOLOAD_MASK)) begin
      noloadMask_q <= regWrData[CHG_LSB +: CHG_W];
    end
  end

  // one gate per event; mask bits 17..0 gate nothing in this block
  always_comb begin
    evtGate = '0;
    evtGate[7] = status_q[EVT_LSB+7] && interrupt_enable_low_q[EVT_LSB+7];
    evtGate[6] = status_q[EVT_LSB+6] && interrupt_enable_low_q[EVT_LSB+6];
    evtGate[5] = status_q[EVT_LSB+5] && interrupt_enable_low_q[EVT_LSB+5];
    evtGate[4] = status_q[EVT_LSB+4] && interrupt_enable_low_q[EVT_LSB+4];
    evtGate[3] = status_q[EVT_LSB+3] && interrupt_enable_low_q[EVT_LSB+3];
    evtGate[2] = status_q[EVT_LSB+2] && interrupt_enable_low_q[EVT_LSB+2];
    evtGate[1] = status_q[EVT_LSB+1] && interrupt_enable_low_q[EVT_LSB+1];
    evtGate[0] = status_q[EVT_LSB] && interrupt_enable_low_q[EVT_LSB];
  end

  assign chgHit = |(status_q[CHG_LSB +: CHG_W] & noloadMask_q);

  assign errHit = |status_q[ERR_LSB +: ERR_W];

  // or of all causes; registered so irq never glitches
  always_ff @(posedge core_clk) begin
    if (clrAll) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= chgHit || (|evtGate) || errHit;
    end
  end

  assign irq = irq_q;

  // event level register image; bits 31..17 read zero
  always_comb begin
    eventLevel = '0;
    eventLevel[LVL_DIP_LSB +: 3] = dip_q;
    eventLevel[LVL_SWELL_LSB +: 3] = swell_q;
    eventLevel[LVL_SIGN_LSB +: 4] = pulseSign_q;
    eventLevel[LVL_NOLOAD_LSB +: 3] = noloadLevel_q[2:0];
    eventLevel[LVL_NOLOAD_LSB+3 +: 3] = noloadLevel_q[5:3];
    eventLevel[LVL_WFREADY_BIT] = wfReady_q;
  end

  // read decode; unmapped addresses read zero
  always_comb begin
    rdMux = READ_IDLE;
    if (regAddr == OFS_NOLOAD_CHANGE) begin
      rdMux = status_q;
    end else if (regAddr == OFS_EVENT_LEVEL) begin
      rdMux = eventLevel;
    end else if (regAddr == OFS_INT_ENABLE_LOW) begin
      rdMux = {6'h00, interrupt_enable_low_q};
    end else if (regAddr == OFS_NOLOAD_MASK) begin
      rdMux = {27'h000_0000, noloadMask_q};
    end else if (regAddr == OFS_PHASE_NOLOAD) begin
      rdMux = {14'h0000, phaseNoload_q};
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rdData_q <= READ_IDLE;
    end else if (regRdEn) begin
      rdData_q <= rdMux;
    end else begin
      rdData_q <= READ_IDLE;
    end
  end

  assign regRdData = rdData_q;

endmodule : mesam_ctrl

// ---- mesam_ctrl_chk.sv ----
// mesam_ctrl_chk: port-level assertions for the event and mask block.
// assumes it is bound to mesam_ctrl; the mask is mirrored from bus writes.
`timescale 1ns/1ps
module mesam_ctrl_chk
  import mesam_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [11:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [31:0] regRdData,
  input wire logic [2:0] dipIn,
  input wire logic [2:0] swellIn,
  input wire logic tempReady,
  input wire logic currentSumMismatch,
  input wire logic waveformTrigger,
  input wire logic powerReady,
  input wire logic fatalError0,
  input wire logic irq
);
  logic [25:0] mask_q;
  logic [1:0] soft_q;
  logic err0_q;
  // mask mirror; a soft reset clears it one edge after its write
  always_ff @(posedge core_clk) begin
    if (!resetn || soft_q[0]) begin
      mask_q <= 26'h000_0000;
    end else if (regWrEn && regAddr == OFS_INT_ENABLE_LOW) begin
      mask_q <= regWrData[25:0];
    end
  end
  // soft reset pipeline, used to keep irq checks out of its window
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      soft_q <= 2'h0;
    end else begin
      soft_q <= {soft_q[0], regWrEn && regAddr == OFS_SOFT_RESET && regWrData[SOFT_RESET_BIT]};
    end
  end
  // error mirror; only a reset drops it, so irq must stay up meanwhile
  always_ff @(posedge core_clk) begin
    if (!resetn || soft_q[0]) begin
      err0_q <= 1'b0;
    end else if (fatalError0) begin
      err0_q <= 1'b1;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // an event arriving while its mask bit is open and nothing disturbs it
  sequence s_ev(e, int b);
    e && mask_q[b] && !regWrEn && soft_q == 2'h0;
  endsequence
  // levels cleared by a soft reset reload one edge later, so skip that window
  sequence s_quiet_rd;
    $stable({swellIn, dipIn})[*2] ##0 (regRdEn && regAddr == OFS_EVENT_LEVEL && soft_q == 2'h0);
  endsequence
  property p_temp; s_ev(tempReady, 25) |-> ##2 irq; endproperty
  a_temp: assert property (p_temp) else $error("temp event gave no irq");
  property p_mism; s_ev(currentSumMismatch, 24) |-> ##2 irq; endproperty
  a_mism: assert property (p_mism) else $error("mismatch event gave no irq");
  property p_trig; s_ev(waveformTrigger, 22) |-> ##2 irq; endproperty
  a_trig: assert property (p_trig) else $error("trigger event gave no irq");
  property p_pwr; s_ev(powerReady, 18) |-> ##2 irq; endproperty
  a_pwr: assert property (p_pwr) else $error("power event gave no irq");
  property p_err;
    $past(err0_q) && soft_q == 2'h0 |-> irq;
  endproperty
  a_err: assert property (p_err) else $error("fatal error irq not held");
  property p_rsv; regRdEn && regAddr == OFS_INT_ENABLE_LOW |=> regRdData[31:26] == 6'h00;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved mask bits not zero");
  property p_mask_rd;
    regRdEn && regAddr == OFS_INT_ENABLE_LOW |=> regRdData[25:0] == $past(mask_q);
  endproperty
  a_mask_rd: assert property (p_mask_rd) else $error("mask read back wrong");
  property p_level; s_quiet_rd |=> regRdData[5:0] == $past({swellIn, dipIn}); endproperty
  a_level: assert property (p_level) else $error("dip or swell level wrong");
endmodule : mesam_ctrl_chk

bind mesam_ctrl mesam_ctrl_chk u_chk (.core_clk(core_clk), .resetn(resetn),
  .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
  .regRdData(regRdData), .dipIn(dipIn), .swellIn(swellIn), .tempReady(tempReady),
  .currentSumMismatch(currentSumMismatch), .waveformTrigger(waveformTrigger),
  .powerReady(powerReady), .fatalError0(fatalError0), .irq(irq));

// ---- mesam_ctrl_bench.sv ----
// mesam_ctrl_bench: directed scenarios for the event and mask block.
// assumes the bench owns every input; a 10 MHz core_clk.
`timescale 1ns/1ps
module mesam_ctrl_bench
  import mesam_pkg::*;
;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [11:0] regAddr = 12'h000;
  logic [31:0] regWrData = 32'h0000_0000;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  logic [31:0] regRdData;
  logic [17:0] noloadIn = 18'h0_0000;
  logic [2:0] dipIn = 3'h0;
  logic [2:0] swellIn = 3'h0;
  logic [3:0] pin = 4'hF;
  logic [3:0] pulseSignIn = 4'h0;
  logic [8:0] evt = 9'h000;
  logic [1:0] fatal = 2'h0;
  logic irq;
  int mismatches = 0;
  int checks = 0;
  mesam_ctrl dut (
    .core_clk(core_clk), .resetn(resetn), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .noloadIn(noloadIn),
    .dipIn(dipIn), .swellIn(swellIn), .energyPulseOut1(pin[0]), .energyPulseOut2(pin[1]),
    .energyPulseOut3(pin[2]), .energyPulseOut4(pin[3]), .pulseSignIn(pulseSignIn),
    .waveformSampleReady(evt[8]), .tempReady(evt[7]), .currentSumMismatch(evt[6]),
    .resampledBufferFull(evt[5]), .waveformTrigger(evt[4]), .distortionPfReady(evt[3]),
    .multicycleRmsReady(evt[2]), .halfcycleRmsReady(evt[1]), .powerReady(evt[0]),
    .fatalError0(fatal[0]), .fatalError1(fatal[1]), .irq(irq)
  );
  // 100 ns period
  initial begin
    forever #50 core_clk = ~core_clk;
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regWrEn <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge core_clk);
    regWrEn <= 1'b0;
  endtask : wr
  // read data is looked at only in the cycle after the strobe
  task automatic rchk(input string n, input logic [11:0] a, input logic [31:0] m,
                      input logic [31:0] e);
    @(posedge core_clk);
    regRdEn <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRdEn <= 1'b0;
    #1 chk(n, regRdData & m, e);
    // back on an edge so the caller's next drive lands on it
    @(posedge core_clk);
  endtask : rchk
  task automatic ichk(input logic e);
    tick(2);
    #1 chk("irq", {31'h0, irq}, {31'h0, e});
  endtask : ichk
  task automatic ev(input int i);
    @(posedge core_clk);
    evt[i] <= 1'b1;
    @(posedge core_clk);
    evt[i] <= 1'b0;
  endtask : ev
  task automatic t_regs();
    rchk("status", OFS_NOLOAD_CHANGE, ALL, 32'h0);
    rchk("unmapped", 12'h400, ALL, 32'h0);
    wr(OFS_INT_ENABLE_LOW, ALL);
    rchk("mask", OFS_INT_ENABLE_LOW, ALL, 32'h03FF_FFFF);
    wr(OFS_EVENT_LEVEL, ALL);
    rchk("level", OFS_EVENT_LEVEL, ALL, 32'h0000_FC00);
    ichk(1'b0);
  endtask : t_regs
  // each event: other mask bits keep irq low, its own bit raises it
  task automatic t_events();
    for (int i = 0; i < 8; i++) begin
      wr(OFS_INT_ENABLE_LOW, 32'h03FC_0000 & ~(32'h1 << (18 + i)));
      ev(i);
      rchk("flag", OFS_NOLOAD_CHANGE, ALL, 32'h1 << (18 + i));
      ichk(1'b0);
      wr(OFS_INT_ENABLE_LOW, 32'h1 << (18 + i));
      ichk(1'b1);
      wr(OFS_NOLOAD_CHANGE, 32'h1 << (18 + i));
      ichk(1'b0);
      ev(i);
      ichk(1'b1);
      wr(OFS_NOLOAD_CHANGE, ALL);
    end
  endtask : t_events
  // one phase of each type enters then leaves no load
  task automatic t_noload();
    wr(OFS_NOLOAD_MASK, 32'h1F);
    for (int t = 0; t < 6; t++) begin
      noloadIn <= 18'h1 << (3 * t);
      tick(2);
      rchk("nl enter", OFS_NOLOAD_CHANGE, ALL, (t < 5) ? 32'h1 << t : 32'h0);
      rchk("nl lvl", OFS_EVENT_LEVEL, 32'hFC00, 32'hFC00 & ~(32'h400 << t));
      rchk("nl phase", OFS_PHASE_NOLOAD, ALL, 32'h1 << (3 * t));
      ichk(t < 5);
      wr(OFS_NOLOAD_CHANGE, 32'h1F);
      noloadIn <= 18'h0_0000;
      tick(2);
      rchk("nl leave", OFS_NOLOAD_CHANGE, ALL, (t < 5) ? 32'h1 << t : 32'h0);
      wr(OFS_NOLOAD_CHANGE, 32'h1F);
    end
  endtask : t_noload
  task automatic t_levels();
    for (int k = 0; k < 8; k++) begin
      dipIn <= 3'(k);
      swellIn <= 3'(~k);
      tick(3);
      rchk("dip swell", OFS_EVENT_LEVEL, 32'h3F, {26'h0, 3'(~k), 3'(k)});
    end
    ev(8);
    rchk("ready", OFS_EVENT_LEVEL, 32'h1_0000, 32'h1_0000);
    rchk("ready rd", OFS_EVENT_LEVEL, 32'h1_0000, 32'h0);
  endtask : t_levels
  // sign moves without a pulse must not show until the pin falls
  task automatic t_pulse();
    logic [3:0] sg;
    sg = 4'h0;
    for (int k = 0; k < 4; k++) begin
      for (int s = 1; s >= 0; s--) begin
        pulseSignIn[k] <= s[0];
        tick(3);
        rchk("sign held", OFS_EVENT_LEVEL, 32'h3C0, {22'h0, sg, 6'h0});
        pin[k] <= 1'b0;
        tick(3);
        pin[k] <= 1'b1;
        tick(6);
        sg[k] = s[0];
        rchk("sign", OFS_EVENT_LEVEL, 32'h3C0, {22'h0, sg, 6'h0});
      end
    end
  endtask : t_pulse
  // errors survive write-one, clear by soft then by hard reset
  task automatic t_fatal();
    for (int f = 0; f < 2; f++) begin
      // second error with every mask closed: irq must still rise
      wr(OFS_INT_ENABLE_LOW, (f == 0) ? 32'h03FF_FFFF : 32'h0000_0000);
      fatal[f] <= 1'b1;
      tick(1);
      fatal[f] <= 1'b0;
      ichk(1'b1);
      wr(OFS_NOLOAD_CHANGE, ALL);
      rchk("fatal", OFS_NOLOAD_CHANGE, ALL, 32'h1000_0000 << f);
      tick(8);
      if (f == 0) begin
        wr(OFS_SOFT_RESET, 32'h1);
        tick(3);
      end else begin
        resetn <= 1'b0;
        tick(2);
        resetn <= 1'b1;
        tick(1);
      end
      rchk("cleared", OFS_NOLOAD_CHANGE, ALL, 32'h0);
      rchk("mask clr", OFS_INT_ENABLE_LOW, ALL, 32'h0);
      ichk(1'b0);
    end
  endtask : t_fatal
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test
  initial begin
    tick(20);
    resetn <= 1'b1;
    tick(1);
    t_regs();
    t_events();
    t_noload();
    t_levels();
    t_pulse();
    t_fatal();
    finish_test();
  end
  // hang guard
  initial begin
    tick(20000);
    mismatches++;
    finish_test();
  end
endmodule : mesam_ctrl_bench
